/* File: include/pcie_tag_alloc_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the tag and
//          completion timeout block.
// Assumes: Byte addresses on a 32-bit Wishbone bus, clock period in ns.
// Notes:   Definitions only.
`ifndef PCIE_TAG_ALLOC_REGS_SVH
`define PCIE_TAG_ALLOC_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define OFS_STEER_CTRL    8'h00
`define OFS_TXQ_CTRL      8'h04
`define OFS_RXQ_CTRL      8'h08
`define OFS_GEN_CTRL      8'h0c
`define OFS_DEV_CTRL2     8'h10
`define OFS_STATUS        8'h14

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define STEER_SYS_DIS_BIT 0
`define STEER_VER_BIT     1
`define TPH_SYS_EN_BIT    2
`define TXQ_DESC_STEER    8
`define TXQ_DESC_TPH      9
`define RXQ_DESC_STEER    8
`define RXQ_HDR_STEER     9
`define RXQ_PAY_STEER     10
`define RXQ_DESC_TPH      11
`define RXQ_PAY_TPH       12
`define GEN_RESEND_BIT    0
`define DC2_TO_DIS_BIT    4

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define RST_STEER_CTRL    32'h0000_0001
`define RST_GEN_CTRL      32'h0000_0007
`define RST_DEV_CTRL2     32'h0000_0000

// -----------------------------------------------------------------------------
// Tag values and timing
// -----------------------------------------------------------------------------
`define TAG_TX_DESC_RD    8'h18
`define TAG_RX_DESC_RD    8'h1c
`define TAG_TX_WB         8'h02
`define TAG_RX_WB         8'h04
`define TAG_WR_DATA       8'h06
`define TAG_MSI           8'h1e
`define TAG_NO_HINT       8'h00
`define TAG_MSG           8'h00
`define CLK_PERIOD_NS     4
`define TICK_NS           1000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)
`define TO_US_DEFAULT     26'd16000
`define TO_US_50US        26'd50
`define TO_US_100US       26'd100
`define TO_US_10MS        26'd10000
`define TO_US_55MS        26'd55000
`define TO_US_210MS       26'd210000
`define TO_US_900MS       26'd900000
`define TO_US_3500MS      26'd3500000
`define TO_US_13S         26'd13000000
`define TO_US_64S         26'd64000000

`endif

/* File: include/pcie_tag_pkg.sv */
// Purpose: Types shared by the tag allocator and its bench.
// Assumes: Eight read trackers: six data slots and two descriptor fetches.
// Notes:   Constants live in pcie_tag_alloc_regs.svh.
package pcie_tag_pkg;

  // Kind of request presented by an internal client.
  typedef enum logic [2:0] {
    RD_DATA, RD_TX_DESC, RD_RX_DESC, WR_TX_WB, WR_RX_WB, WR_DATA, WR_MSI, MSG
  } req_kind_type;

  // Request from the DMA, interrupt or descriptor clients.
  typedef struct packed {
    logic         valid;
    req_kind_type kind;
    logic [2:0]   slot;     // Data read slot 0..5.
    logic         header;   // Write data is a receive header, else payload.
  } req_type;

  // Header fields handed to the transmitter.
  typedef struct packed {
    logic       valid;
    logic       is_read;
    logic       resend;
    logic [7:0] tag;
  } tlp_type;

  // Completion header from the receiver.
  typedef struct packed {
    logic       valid;
    logic [7:0] tag;
    logic       last;
  } cpl_type;

  // Routing decision for completion data.
  typedef struct packed {
    logic       valid;
    logic [2:0] client;     // 0..5 data slot, 6 Tx descriptor, 7 Rx descriptor.
    logic       last;
    logic       stale;      // Request already ended; data must be dropped.
  } route_type;

endpackage

/* File: rtl/pcie_tag_alloc_cpl_timeout.sv */
// Purpose: Tag allocation for outgoing requests and completion timeout tracking.
// Assumes: Transmitter takes tlp_o while tlp_ready_i is high; completions arrive
//          with the tag of their request.
// Notes:   Registers reached over classic Wishbone, one word each.
`include "pcie_tag_alloc_regs.svh"

// Operation
// - Single function; capture device number from config.
// - Messages always carry tag zero.
// - Data reads tagged 0..5; completions steered by tag.
// - Descriptor reads tagged 0x18 and 0x1C only.
// - Steering off: write tags 0x2, 0x4, 0x6.
// - Steering off: interrupt writes tagged 0x1E.
// - Legacy, type disabled: use debug write tags.
// - Version one, type disabled: write tag zero.
// - Version one: messages, interrupts use no-hint tag.
// - Legacy enabled: tag {0000, cpu[2:0], 1}.
// - Version one enabled: tag is full CPU identifier.
// - Hints enabled: tag is full CPU identifier.
// - Start timeout timer when non-posted request sent.
// - Timeout enable in device control 2, default on.
// - Resend timed-out request when resend enabled.
// - Resends limited by programmable count, default three.
// - Support all timeout period ranges.
// - Request done after last completion; partial kept.
module pcie_tag_alloc_cpl_timeout
  import pcie_tag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clk_i,          // Core clock, 250 MHz.
  input  wire logic        rst_i,          // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte lanes.
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
  output logic      [31:0] wb_dat_o,       // Wishbone read data.
  output logic             wb_ack_o,       // Wishbone acknowledge.
  input  wire logic        cfg_type0_wr_i, // Type 0 configuration write seen.
  input  wire logic [4:0]  cfg_dev_num_i,  // Device number of that write.
  input  wire req_type     req_i,          // Client request, held until ack.
  output logic             req_ack_o,      // Request taken, one-cycle pulse.
  output tlp_type          tlp_o,          // Header to transmitter.
  input  wire logic        tlp_ready_i,    // Transmitter takes tlp_o.
  input  wire cpl_type     cpl_i,          // Completion header.
  output route_type        route_o,        // Completion routing.
  output logic             timeout_o,      // Request abandoned, one-cycle pulse.
  output logic      [7:0]  timeout_tag_o   // Tag of the abandoned request.
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0] steer_q, txq_q, rxq_q, gen_q, dc2_q;
  logic [4:0]  dev_num_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // Byte-lane write mask built from the select lines.
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // A write lands on the edge at which the master samples ack high.
  wire        wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  wire        hit_steer = (wb_adr_i == `OFS_STEER_CTRL);
  wire        hit_txq   = (wb_adr_i == `OFS_TXQ_CTRL);
  wire        hit_rxq   = (wb_adr_i == `OFS_RXQ_CTRL);
  wire        hit_gen   = (wb_adr_i == `OFS_GEN_CTRL);
  wire        hit_dc2   = (wb_adr_i == `OFS_DEV_CTRL2);
  wire        hit_stat  = (wb_adr_i == `OFS_STATUS);

  // Control fields.
  wire        steer_sys_off = steer_q[`STEER_SYS_DIS_BIT];
  wire        steer_v1      = steer_q[`STEER_VER_BIT];
  wire        tph_sys       = steer_q[`TPH_SYS_EN_BIT];
  wire        to_enable     = ~dc2_q[`DC2_TO_DIS_BIT];
  wire        resend_en     = gen_q[`GEN_RESEND_BIT];
  wire [3:0]  resend_max    = gen_q[4:1];
  wire [3:0]  to_range      = dc2_q[3:0];

  // Tracker state, one per read tag.
  logic [7:0]  busy_q, pend_q;
  logic [25:0] timer_q [8];
  logic [3:0]  tries_q [8];

  // Read data selection; unmapped addresses read as zero.
  logic [31:0] rsel;
  always_comb begin
    if (hit_steer) begin
      rsel = steer_q;
    end else if (hit_txq) begin
      rsel = txq_q;
    end else if (hit_rxq) begin
      rsel = rxq_q;
    end else if (hit_gen) begin
      rsel = gen_q;
    end else if (hit_dc2) begin
      rsel = dc2_q;
    end else if (hit_stat) begin
      rsel = {11'h000, dev_num_q, pend_q, busy_q};
    end else begin
      rsel = 32'h0000_0000;
    end
  end

  // Bus slave: one wait state, ack drops in the cycle after it is given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= wb_req;
      rdata_q <= rsel;
    end
  end

  // Software-written registers; writes land with the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_q <= `RST_STEER_CTRL;
      txq_q   <= 32'h0000_0000;
      rxq_q   <= 32'h0000_0000;
      gen_q   <= `RST_GEN_CTRL;
      dc2_q   <= `RST_DEV_CTRL2;
    end else if (wb_wr) begin
      if (hit_steer) steer_q <= (steer_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_0007);
      if (hit_txq)   txq_q   <= (txq_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_03ff);
      if (hit_rxq)   rxq_q   <= (rxq_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_1fff);
      if (hit_gen)   gen_q   <= (gen_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_001f);
      if (hit_dc2)   dc2_q   <= (dc2_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_001f);
    end
  end

  // The function's device number follows each type 0 configuration write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_num_q <= 5'h00;
    end else if (cfg_type0_wr_i) begin
      dev_num_q <= cfg_dev_num_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Tag selection
  // ---------------------------------------------------------------------------
  // Per-type enables and identifiers. Write data of a header goes with header
  // steering; hints are only defined for descriptors and payload.
  wire        is_tx   = (req_i.kind == WR_TX_WB);
  wire [7:0]  cpu_id  = is_tx ? txq_q[7:0] : rxq_q[7:0];
  wire        typ_steer = is_tx ? txq_q[`TXQ_DESC_STEER] :
                          (req_i.kind == WR_RX_WB) ? rxq_q[`RXQ_DESC_STEER] :
                          req_i.header ? rxq_q[`RXQ_HDR_STEER] : rxq_q[`RXQ_PAY_STEER];
  wire        typ_tph = is_tx ? txq_q[`TXQ_DESC_TPH] :
                        (req_i.kind == WR_RX_WB) ? rxq_q[`RXQ_DESC_TPH] :
                        ~req_i.header & rxq_q[`RXQ_PAY_TPH];
  wire [7:0]  dbg_tag = is_tx ? `TAG_TX_WB :
                        (req_i.kind == WR_RX_WB) ? `TAG_RX_WB : `TAG_WR_DATA;

  // Write tag: hints first, then steering mode, then the debug table.
  logic [7:0] wr_tag;
  always_comb begin
    if (tph_sys && typ_tph) begin
      wr_tag = cpu_id;
    end else if (steer_sys_off) begin
      wr_tag = dbg_tag;
    end else if (typ_steer && steer_v1) begin
      wr_tag = cpu_id;
    end else if (typ_steer) begin
      wr_tag = {4'h0, cpu_id[2:0], 1'b1};
    end else if (steer_v1) begin
      wr_tag = `TAG_NO_HINT;
    end else begin
      wr_tag = dbg_tag;
    end
  end

  // Tag and tracker index for the presented request.
  logic [7:0] new_tag;
  logic [2:0] new_idx;
  logic       new_read;
  always_comb begin
    new_idx  = req_i.slot;
    new_read = 1'b1;
    case (req_i.kind)
      RD_DATA: begin
        new_tag = {5'h00, req_i.slot};
      end
      RD_TX_DESC: begin
        new_tag = `TAG_TX_DESC_RD;
        new_idx = 3'd6;
      end
      RD_RX_DESC: begin
        new_tag = `TAG_RX_DESC_RD;
        new_idx = 3'd7;
      end
      WR_MSI: begin
        new_read = 1'b0;
        new_tag  = (!steer_sys_off && steer_v1) ? `TAG_NO_HINT : `TAG_MSI;
      end
      MSG: begin
        new_read = 1'b0;
        new_tag  = steer_v1 ? `TAG_NO_HINT : `TAG_MSG;
      end
      default: begin
        new_read = 1'b0;
        new_tag  = wr_tag;
      end
    endcase
  end

  // Tracker index to read tag.
  function automatic logic [7:0] idx_tag(input logic [2:0] idx);
    if (idx == 3'd6) begin
      return `TAG_TX_DESC_RD;
    end else if (idx == 3'd7) begin
      return `TAG_RX_DESC_RD;
    end else begin
      return {5'h00, idx};
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Issue arbitration
  // ---------------------------------------------------------------------------
  // Resends win over new requests so a stalled slot is freed first. A read
  // whose tag is still outstanding waits; slots above five are refused.
  logic       rs_any;
  logic [2:0] rs_idx;
  always_comb begin
    rs_any = 1'b0;
    rs_idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (pend_q[i]) begin
        rs_any = 1'b1;
        rs_idx = 3'(i);
      end
    end
  end

  wire can_issue = ~tlp_o.valid | tlp_ready_i;
  wire slot_ok   = (req_i.kind != RD_DATA) || (req_i.slot <= 3'd5);
  wire new_go    = can_issue & ~rs_any & req_i.valid & ~req_ack_o & slot_ok
                   & ~(new_read & busy_q[new_idx]);
  wire rs_go     = can_issue & rs_any;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlp_o     <= '0;
      req_ack_o <= 1'b0;
    end else begin
      req_ack_o <= new_go;
      if (rs_go) begin
        tlp_o <= '{valid: 1'b1, is_read: 1'b1, resend: 1'b1, tag: idx_tag(rs_idx)};
      end else if (new_go) begin
        tlp_o <= '{valid: 1'b1, is_read: new_read, resend: 1'b0, tag: new_tag};
      end else if (tlp_ready_i) begin
        tlp_o.valid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Completion timeout
  // ---------------------------------------------------------------------------
  // Period limit in microsecond ticks for each range code.
  logic [25:0] limit;
  always_comb begin
    case (to_range)
      4'h1:    limit = `TO_US_50US;
      4'h2:    limit = `TO_US_100US;
      4'h5:    limit = `TO_US_10MS;
      4'h6:    limit = `TO_US_55MS;
      4'h9:    limit = `TO_US_210MS;
      4'ha:    limit = `TO_US_900MS;
      4'hd:    limit = `TO_US_3500MS;
      4'he:    limit = `TO_US_13S;
      4'hf:    limit = `TO_US_64S;
      default: limit = `TO_US_DEFAULT;
    endcase
  end

  // One-microsecond tick shared by all trackers.
  logic [15:0] pre_q;
  wire         tick = (pre_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // Completion lookup: which tracker a tag belongs to.
  wire       cpl_data = (cpl_i.tag <= 8'h05);
  wire       cpl_map  = cpl_data | (cpl_i.tag == `TAG_TX_DESC_RD) |
                        (cpl_i.tag == `TAG_RX_DESC_RD);
  wire [2:0] cpl_idx  = cpl_data ? cpl_i.tag[2:0] :
                        (cpl_i.tag == `TAG_TX_DESC_RD) ? 3'd6 : 3'd7;
  wire       cpl_live = cpl_i.valid & cpl_map & busy_q[cpl_idx];

  // Tracker update. A tracker is armed when its read is sent, ends on its last
  // completion, and on expiry either asks for a resend or gives up. A last
  // completion beats an expiry in the same cycle so arrived data is never lost.
  logic [7:0] to_hit;
  logic [7:0] to_end;
  logic [2:0] to_idx;
  always_comb begin
    to_hit = 8'h00;
    to_end = 8'h00;
    to_idx = 3'd0;
    for (int i = 0; i < 8; i++) begin
      to_hit[i] = busy_q[i] & ~pend_q[i] & tick & to_enable & (timer_q[i] >= limit);
      to_end[i] = to_hit[i] & ~(cpl_live & cpl_i.last & (cpl_idx == 3'(i)))
                  & ~(resend_en & (tries_q[i] < resend_max));
      if (to_end[i]) begin
        to_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 8'h00;
      pend_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        timer_q[i] <= 26'd0;
        tries_q[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (new_go && new_read && new_idx == 3'(i)) begin
          busy_q[i]  <= 1'b1;
          timer_q[i] <= 26'd0;
          tries_q[i] <= 4'h0;
        end else if (rs_go && rs_idx == 3'(i)) begin
          pend_q[i]  <= 1'b0;
          timer_q[i] <= 26'd0;
        end else if (cpl_live && cpl_i.last && cpl_idx == 3'(i)) begin
          busy_q[i] <= 1'b0;
          pend_q[i] <= 1'b0;
        end else if (to_hit[i]) begin
          if (resend_en && tries_q[i] < resend_max) begin
            pend_q[i]  <= 1'b1;
            tries_q[i] <= tries_q[i] + 4'h1;
          end else begin
            busy_q[i] <= 1'b0;
          end
        end else if (busy_q[i] && tick && to_enable) begin
          timer_q[i] <= timer_q[i] + 26'd1;
        end
      end
    end
  end

  // Abandon report: one pulse per cycle in which trackers give up; the highest tracker index is reported.
  wire give_up = |to_end;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_o     <= 1'b0;
      timeout_tag_o <= 8'h00;
    end else begin
      timeout_o     <= give_up;
      timeout_tag_o <= give_up ? idx_tag(to_idx) : timeout_tag_o;
    end
  end

  // Completion routing. Data for a request that has ended is flagged stale so
  // the client drops it; partial data before expiry is kept by the client.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_o <= '0;
    end else begin
      route_o <= '{valid: cpl_i.valid & cpl_map, client: cpl_idx,
                   last: cpl_i.last, stale: ~cpl_live};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule

/* File: verif/pcie_tag_alloc_cpl_timeout_properties.sv */
// Purpose: Port-level properties of the tag allocator.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound to the design from the bench top file.
module pcie_tag_alloc_cpl_timeout_properties
  import pcie_tag_pkg::*;
(
  input wire logic      clk_i,       // Core clock.
  input wire logic      rst_i,       // Synchronous reset.
  input wire req_type   req_i,       // Client request.
  input wire logic      req_ack_o,   // Request taken.
  input wire tlp_type   tlp_o,       // Header to transmitter.
  input wire logic      tlp_ready_i, // Transmitter takes header.
  input wire cpl_type   cpl_i,       // Completion header.
  input wire route_type route_o      // Completion routing.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  // The taken request is the one seen one edge before the ack.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_MSG_TAG: assert property (req_ack_o && $past(req_i.kind) == MSG
    |-> tlp_o.tag == 8'h00) else $error("message tag not zero");
  AST_DATA_TAG: assert property (req_ack_o && $past(req_i.kind) == RD_DATA
    |-> tlp_o.is_read && tlp_o.tag == {5'h00, $past(req_i.slot)}) else $error("data tag");
  AST_DESC_TAG: assert property (req_ack_o && $past(req_i.kind) == RD_TX_DESC
    |-> tlp_o.is_read && tlp_o.tag == 8'h18) else $error("tx descriptor tag");
  AST_READ_SET: assert property (tlp_o.valid && tlp_o.is_read
    |-> tlp_o.tag inside {[8'h00:8'h05], 8'h18, 8'h1c}) else $error("read tag unused");
  AST_ROUTE_DATA: assert property (cpl_i.valid && cpl_i.tag < 8'h06
    |=> route_o.valid && route_o.client == $past(cpl_i.tag[2:0])) else $error("data route");
  AST_ROUTE_DESC: assert property (cpl_i.valid && cpl_i.tag == 8'h1c
    |=> route_o.valid && route_o.client == 3'd7) else $error("rx descriptor route");
  AST_ROUTE_LAST: assert property (route_o.valid
    |-> $past(cpl_i.valid) && route_o.last == $past(cpl_i.last)) else $error("last flag");
  AST_TLP_HOLD: assert property (tlp_o.valid && !tlp_ready_i
    |=> tlp_o.valid && $stable(tlp_o.tag)) else $error("header dropped early");
  AST_RESEND_READ: assert property (tlp_o.valid && tlp_o.resend
    |-> tlp_o.is_read) else $error("posted request resent");
endmodule

/* File: verif/pcie_upstream_model.sv */
// Purpose: Upstream port: takes headers, answers reads with two completions.
// Assumes: Completions of one tag come back in order.
// Notes:   Muting swallows reads so the timer runs out.
module pcie_upstream_model
  import pcie_tag_pkg::*;
(
  input  wire logic    clk_i,   // Core clock.
  input  wire logic    rst_i,   // Synchronous reset.
  input  wire logic    mute_i,  // Swallow reads unanswered.
  input  wire tlp_type tlp_i,   // Header from the device.
  output logic         ready_o, // Header taken this edge.
  output cpl_type      cpl_o    // Completion to the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pend_q[$];
  // Random stalls and delays; an idle completion bus shows the inverted tag.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      cpl_o   <= '0;
      pend_q.delete();
    end else begin
      ready_o <= ($urandom_range(2) != 0);
      if (tlp_i.valid && ready_o && tlp_i.is_read && !mute_i) begin
        pend_q.push_back({tlp_i.tag, 1'b0});
        pend_q.push_back({tlp_i.tag, 1'b1});
      end
      if (pend_q.size() != 0 && $urandom_range(1) == 1)
        cpl_o <= {1'b1, pend_q.pop_front()};
      else
        cpl_o <= {1'b0, ~cpl_o.tag, 1'b0};
    end
  end
endmodule

/* File: verif/tb_pcie_tag_alloc_cpl_timeout.sv */
// Purpose: Self-checking bench for tag allocation and completion timeout.
// Assumes: TICK_CYCLES of 2, so the 50 us range lasts 100 clocks.
// Notes:   Expected header tags queue up; a monitor pops them per transfer.
module tb_pcie_tag_alloc_cpl_timeout
  import pcie_tag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mute;
  logic [7:0]  wb_adr_i, timeout_tag_o, to_exp, cpu_t, cpu_r;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic        cfg_type0_wr_i, req_ack_o, tlp_ready_i, timeout_o;
  logic [4:0]  cfg_dev_num_i;
  req_type     req_i;
  tlp_type     tlp_o;
  cpl_type     cpl_i;
  route_type   route_o;
  logic [7:0]  exp_q[$];
  int          num_errors, comparisons, to_cnt, i;
  logic [3:0]  i_codes[9] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he, 4'hf};

  pcie_tag_alloc_cpl_timeout #(.TICK_CYCLES(2)) pcie_tag_alloc_cpl_timeout_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .cfg_type0_wr_i, .cfg_dev_num_i, .req_i, .req_ack_o, .tlp_o,
    .tlp_ready_i, .cpl_i, .route_o, .timeout_o, .timeout_tag_o);
  pcie_upstream_model pcie_upstream_model_inst (.clk_i, .rst_i, .mute_i(mute),
    .tlp_i(tlp_o), .ready_o(tlp_ready_i), .cpl_o(cpl_i));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Request held until acked; a busy read tag makes it wait.
  task automatic rq(input req_kind_type k, input logic [2:0] s, input logic h,
                    input logic [7:0] t);
    int n;
    @(posedge clk_i);
    exp_q.push_back(t);
    req_i <= '{1'b1, k, s, h};
    n = 0;
    do begin @(posedge clk_i); n++; end while (req_ack_o !== 1'b1 && n < 300);
    req_i.valid <= 1'b0;
  endtask
  task automatic wait_to(input int n);
    int k;
    for (k = 0; k < 3000 && to_cnt < n; k++) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, monitor and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Each header taken by the transmitter consumes the oldest expected tag.
  always @(posedge clk_i) begin
    if (tlp_o.valid === 1'b1 && tlp_ready_i === 1'b1) begin
      check(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) check(tlp_o.tag, exp_q.pop_front());
    end
    if (route_o.valid === 1'b1) check(route_o.stale, 1'b0);
    if (timeout_o === 1'b1) begin
      to_cnt++;
      check(timeout_tag_o, to_exp);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 47'h0};
    {cfg_type0_wr_i, cfg_dev_num_i, mute, req_i} = '0;
    void'($urandom(32'hdbf3));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h00, 0); check(r, 32'h1);
    wb(0, 8'h0c, 0); check(r, 32'h7);
    wb(0, 8'h10, 0); check(r, 32'h0);
    wb(1, 8'h3c, 32'hffff_ffff); wb(0, 8'h3c, 0); check(r, 32'h0);
    cfg_dev_num_i <= $urandom; cfg_type0_wr_i <= 1'b1;
    @(posedge clk_i); cfg_type0_wr_i <= 1'b0;
    wb(1, 8'h14, 32'h0); wb(0, 8'h14, 0); check(r[20:16], cfg_dev_num_i);
    foreach (i_codes[j]) begin
      wb(1, 8'h10, {28'h0, i_codes[j]}); wb(0, 8'h10, 0); check(r[3:0], i_codes[j]);
    end
    $display("registers done");
    for (i = 0; i < 12; i++) rq(RD_DATA, i % 6, 0, i % 6);
    rq(RD_TX_DESC, 0, 0, 8'h18); rq(RD_RX_DESC, 0, 0, 8'h1c);
    rq(WR_TX_WB, 0, 0, 8'h02); rq(WR_RX_WB, 0, 0, 8'h04); rq(WR_DATA, 0, 0, 8'h06);
    rq(WR_MSI, 0, 0, 8'h1e); rq(MSG, 0, 0, 8'h00);
    $display("steering off done");
    cpu_t = $urandom; cpu_r = $urandom;
    wb(1, 8'h00, 0); wb(1, 8'h04, {22'h0, 2'b01, cpu_t}); wb(1, 8'h08, {19'h0, 5'b00110, cpu_r});
    rq(WR_TX_WB, 0, 0, {4'h0, cpu_t[2:0], 1'b1}); rq(WR_DATA, 0, 0, {4'h0, cpu_r[2:0], 1'b1});
    rq(WR_RX_WB, 0, 0, 8'h04); rq(WR_MSI, 0, 0, 8'h1e);
    wb(1, 8'h00, 32'h2);
    rq(WR_TX_WB, 0, 0, cpu_t); rq(WR_DATA, 0, 1, cpu_r);
    rq(WR_RX_WB, 0, 0, 8'h00); rq(WR_MSI, 0, 0, 8'h00); rq(MSG, 0, 0, 8'h00);
    wb(1, 8'h00, 32'h5); wb(1, 8'h04, {22'h0, 2'b10, cpu_t}); wb(1, 8'h08, {19'h0, 5'b01000, cpu_r});
    rq(WR_TX_WB, 0, 0, cpu_t); rq(WR_RX_WB, 0, 0, cpu_r); rq(WR_DATA, 0, 0, 8'h06);
    $display("steering modes done");
    repeat (50) @(posedge clk_i);
    mute <= 1'b1; to_exp = 8'h18;
    wb(1, 8'h10, 32'h1);
    for (i = 0; i < 3; i++) exp_q.push_back(8'h18);
    rq(RD_TX_DESC, 0, 0, 8'h18);
    wait_to(1); check(to_cnt, 1);
    wb(1, 8'h0c, 32'h3); to_exp = 8'h1c;
    exp_q.push_back(8'h1c);
    rq(RD_RX_DESC, 0, 0, 8'h1c);
    wait_to(2); check(to_cnt, 2);
    wb(1, 8'h10, 32'h11); rq(RD_DATA, 2, 0, 8'h02);
    repeat (600) @(posedge clk_i);
    check(to_cnt, 2); check(exp_q.size(), 0);
    $display("timeout done");
    complete_run();
  end
endmodule

bind pcie_tag_alloc_cpl_timeout pcie_tag_alloc_cpl_timeout_properties props_inst (
  .clk_i, .rst_i, .req_i, .req_ack_o, .tlp_o, .tlp_ready_i, .cpl_i, .route_o);
